// ### design/spi_port_regs.svh
// Named constants for the serial port shifter
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH
`define BYTE_W 8
`define BIT_CNT_W 3
`define BIT_LAST 3'h7
`define MSB_POS 7
`define DIV_HALF 8'h05
`define DIV_W 8
`define PORT_COUNT 2
`endif

// ### design/spi_port_pkg.sv
// Types shared by the serial port shifter
package spi_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b11,
      ST_DONE = 2'b10
   } shift_state_e;
   // Pins of one port, split into inputs and drives
   typedef struct packed {
      logic sel_n;
      logic sclk;
      logic serial_in;
   } pins_in_s;
   typedef struct packed {
      logic sel_n;
      logic sel_oe;
      logic sclk;
      logic sclk_oe;
      logic serial_out;
      logic serial_out_oe;
   } pins_out_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } byte_s;
endpackage : spi_port_pkg

// ### design/spi_port_core.sv
// One serial port able to run as master or slave
`timescale 1ns/100ps
`include "spi_port_regs.svh"
module spi_port_core
   import spi_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n,
   input wire logic master_in,
   input wire logic start_in,
   input wire logic [7:0] tx_data_in,
   input wire pins_in_s pins_in,
   output pins_out_s pins_out,
   output byte_s rx_out,
   output logic busy_out
);
   // =====================================================
   // Pin synchronisers, three stages
   logic [2:0] sclk_sync_reg, sel_sync_reg, sin_sync_reg;
   logic [2:0] sclk_sync_next, sel_sync_next, sin_sync_next;
   logic sclk_st_reg, sclk_st_next, sel_st_reg, sel_st_next;
   always_comb begin
      sclk_sync_next = {sclk_sync_reg[1:0], pins_in.sclk};
      sel_sync_next = {sel_sync_reg[1:0], pins_in.sel_n};
      sin_sync_next = {sin_sync_reg[1:0], pins_in.serial_in};
      sclk_st_next = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2] : sclk_st_reg;
      sel_st_next = (sel_sync_reg[1] == sel_sync_reg[2]) ? sel_sync_reg[2] : sel_st_reg;
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sclk_sync_reg <= 3'h0;
         sel_sync_reg <= 3'h7;
         sin_sync_reg <= 3'h0;
         sclk_st_reg <= 1'b0;
         sel_st_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= sclk_sync_next;
         sel_sync_reg <= sel_sync_next;
         sin_sync_reg <= sin_sync_next;
         sclk_st_reg <= sclk_st_next;
         sel_st_reg <= sel_st_next;
      end
   end
   wire logic s_rise = sclk_st_next & ~sclk_st_reg;
   wire logic s_fall = ~sclk_st_next & sclk_st_reg;
   wire logic sel_low = ~sel_st_reg;
   // =====================================================
   // Shift engine
   shift_state_e state_reg, state_next;
   logic [7:0] sh_reg, sh_next;
   logic [`BIT_CNT_W-1:0] cnt_reg, cnt_next;
   logic [`DIV_W-1:0] div_reg, div_next;
   logic sclk_reg, sclk_next, sout_reg, sout_next, smp_reg, smp_next;
   pins_out_s po_reg, po_next;
   byte_s rx_reg, rx_next;
   logic tick;
   logic busy_reg, busy_next;
   always_comb begin
      state_next = state_reg;
      sh_next = sh_reg;
      cnt_next = cnt_reg;
      div_next = div_reg;
      sclk_next = sclk_reg;
      sout_next = sout_reg;
      smp_next = smp_reg;
      rx_next = '{valid: 1'b0, data: rx_reg.data};
      tick = (div_reg == `DIV_HALF);
      if (master_in) begin
         div_next = tick ? '0 : div_reg + 1'b1;
         case (state_reg)
            ST_IDLE: begin
               sclk_next = 1'b0;
               div_next = '0;
               if (start_in) begin
                  sh_next = tx_data_in;
                  sout_next = tx_data_in[`MSB_POS];
                  cnt_next = '0;
                  state_next = ST_SHIFT;
               end
            end
            ST_SHIFT: if (tick) begin
               sclk_next = ~sclk_reg;
               if (!sclk_reg) begin
                  smp_next = sin_sync_reg[2];
               end else begin
                  sh_next = {sh_reg[6:0], smp_reg};
                  sout_next = sh_reg[6];
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg == `BIT_LAST) begin
                     rx_next = '{valid: 1'b1, data: {sh_reg[6:0], smp_reg}};
                     state_next = ST_IDLE;
                  end
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end else begin
         sclk_next = 1'b0;
         case (state_reg)
            ST_IDLE: if (sel_low) begin
               sh_next = tx_data_in;
               sout_next = tx_data_in[`MSB_POS];
               cnt_next = '0;
               state_next = ST_SHIFT;
            end
            ST_SHIFT: begin
               if (!sel_low) begin
                  state_next = ST_IDLE;
               end else if (s_rise) begin
                  smp_next = sin_sync_reg[2];
               end else if (s_fall) begin
                  sh_next = {sh_reg[6:0], smp_reg};
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg == `BIT_LAST) begin
                     rx_next = '{valid: 1'b1, data: {sh_reg[6:0], smp_reg}};
                     sh_next = tx_data_in;
                     sout_next = tx_data_in[`MSB_POS];
                  end else begin
                     sout_next = sh_reg[6];
                  end
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
      // Master drives select high itself; software picks slave via any pin
      po_next.sel_n = 1'b1;
      po_next.sel_oe = master_in;
      po_next.sclk = sclk_next;
      po_next.sclk_oe = master_in;
      po_next.serial_out = sout_next;
      po_next.serial_out_oe = master_in | (sel_low & (state_next == ST_SHIFT));
      // Registered so the busy flag leaves the block straight from a flip-flop
      busy_next = (state_next != ST_IDLE);
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         sh_reg <= 8'h00;
         cnt_reg <= '0;
         div_reg <= '0;
         sclk_reg <= 1'b0;
         sout_reg <= 1'b0;
         smp_reg <= 1'b0;
         po_reg <= '0;
         rx_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sh_reg <= sh_next;
         cnt_reg <= cnt_next;
         div_reg <= div_next;
         sclk_reg <= sclk_next;
         sout_reg <= sout_next;
         smp_reg <= smp_next;
         po_reg <= po_next;
         rx_reg <= rx_next;
         busy_reg <= busy_next;
      end
   end
   assign pins_out = po_reg;
   assign rx_out = rx_reg;
   assign busy_out = busy_reg;

   // Master byte begins: idle and asked to go
   sequence s_master_go;
      master_in && state_reg == ST_IDLE && start_in;
   endsequence
   // Master byte still has bits to move
   sequence s_master_mid;
      master_in && state_reg == ST_SHIFT && cnt_reg != `BIT_LAST;
   endsequence
   a_slave_release: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!master_in && sel_st_reg) |=> !pins_out.serial_out_oe)
      else $error("slave output not released");
   a_master_drive: assert property (@(posedge clk_in) disable iff (!rst_n)
      master_in |=> pins_out.sclk_oe)
      else $error("master not driving clock");
   a_slave_clk_in: assert property (@(posedge clk_in) disable iff (!rst_n)
      $past(!master_in) |-> !pins_out.sclk_oe && !pins_out.sel_oe)
      else $error("slave drives clock");
   // Own select is set at random before each master run in the loop, so an abort on it would show here
   a_sel_ignored: assert property (@(posedge clk_in) disable iff (!rst_n)
      s_master_mid |=> state_reg == ST_SHIFT)
      else $error("master byte cut short");
   a_idle_no_rx: assert property (@(posedge clk_in) disable iff (!rst_n)
      (state_reg == ST_IDLE) |=> !rx_out.valid)
      else $error("byte without transfer");
   a_msb_first: assert property (@(posedge clk_in) disable iff (!rst_n)
      s_master_go |=> pins_out.serial_out == $past(tx_data_in[`MSB_POS]))
      else $error("msb not first");
   a_slave_wait: assert property (@(posedge clk_in) disable iff (!rst_n)
      (!master_in && state_reg == ST_IDLE && sel_st_reg) |=> state_reg == ST_IDLE)
      else $error("slave started without select");
   a_master_clk_low: assert property (@(posedge clk_in) disable iff (!rst_n)
      (master_in && state_reg == ST_IDLE && !start_in) |=> !pins_out.sclk)
      else $error("clock runs idle");
endmodule : spi_port_core

// ### design/spi_master_slave_shifter.sv
// Top: two independent serial ports
`timescale 1ns/100ps
`include "spi_port_regs.svh"
// Operation
// - Each port runs as master or slave per its mode input.
// - Master drives select, clock and serial out; samples serial in.
// - Slave takes select, clock, serial in; drives only serial out.
// - Own select pin matters only in slave mode.
// - Master leaves slave selection to any software-driven general pin.
// - Master holds its own select pin high; a general pin selects the slave.
// - Slave enables on select low, then waits for master clock edges.
// - Master shifts one bit out and one in per clock.
// - Slave captures serial in while presenting its own bits.
// - Full duplex bytes: each byte sent also receives one.
// - Two independent port instances with their own pins.
module spi_master_slave_shifter
   import spi_port_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [1:0] master_in,
   input wire logic [1:0] start_in,
   input wire logic [15:0] tx_data_in,
   input wire pins_in_s [1:0] pins_in,
   output pins_out_s [1:0] pins_out,
   output byte_s [1:0] rx_out,
   output logic [1:0] busy_out
);
   // =====================================================
   // Reset release
   logic [1:0] rst_sync_reg;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   // =====================================================
   // Port instances: index 0 is serial_port_a, 1 is serial_port_b
   genvar g;
   generate
      for (g = 0; g < `PORT_COUNT; g++) begin : g_port
         spi_port_core u_port (
            .clk_in(clk_in),
            .rst_n(rst_sync_reg[1]),
            .master_in(master_in[g]),
            .start_in(start_in[g]),
            .tx_data_in(tx_data_in[g*8 +: 8]),
            .pins_in(pins_in[g]),
            .pins_out(pins_out[g]),
            .rx_out(rx_out[g]),
            .busy_out(busy_out[g])
         );
      end
   endgenerate
endmodule : spi_master_slave_shifter

// ### test/spi_far_slave.sv
// Behavioural far-end slave that answers the master port
`timescale 1ns/100ps
module spi_far_slave (
   input wire logic sel_n_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic [7:0] tx_in,
   output logic miso_out,
   output logic [7:0] rx_out
);
   logic [7:0] sh = 8'h00;
   always @(negedge sel_n_in) sh = tx_in;
   always @(posedge sclk_in) if (!sel_n_in) rx_out = {rx_out[6:0], mosi_in};
   always @(negedge sclk_in) if (!sel_n_in) sh = {sh[6:0], 1'b0};
   // Released line shows the inverse so a stale bit can never pass
   assign miso_out = sel_n_in ? ~sh[7] : sh[7];
endmodule : spi_far_slave

// ### test/testbench.sv
// Self-checking bench: port a as master, port b as slave
`timescale 1ns/100ps
module testbench;
   import spi_port_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [1:0] start = 2'h0;
   logic [1:0] mode = 2'h1;
   logic [15:0] txd = 16'h0000;
   logic a_sel = 1'b1, a_own = 1'b1, b_sel_n = 1'b1, b_sclk = 1'b0, b_mosi = 1'b0;
   logic [7:0] far_tx = 8'h00;
   logic miso;
   logic [7:0] far_rx, got_a, got_b;
   int na = 0, nb = 0, err_count = 0, samples_checked = 0;
   pins_in_s [1:0] pin;
   pins_out_s [1:0] pout;
   byte_s [1:0] rx;
   logic [1:0] busy;
   assign pin[0] = {a_own, 1'b0, miso};
   assign pin[1] = {b_sel_n, b_sclk, b_mosi};
   spi_master_slave_shifter u_spi_master_slave_shifter (.clk_in(clk_in), .rstn_in(rstn_in),
      .master_in(mode), .start_in(start), .tx_data_in(txd), .pins_in(pin), .pins_out(pout),
      .rx_out(rx), .busy_out(busy));
   spi_far_slave u_spi_far_slave (.sel_n_in(a_sel), .sclk_in(pout[0].sclk),
      .mosi_in(pout[0].serial_out), .tx_in(far_tx), .miso_out(miso), .rx_out(far_rx));
   initial forever #2 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (rx[0].valid === 1'b1) begin
         na++;
         got_a = rx[0].data;
      end
      if (rx[1].valid === 1'b1) begin
         nb++;
         got_b = rx[1].data;
      end
   end
   // ==========================================================
   // Checking and verdict
   task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task conclude;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // ==========================================================
   // Transfers; select of port a is a bench general pin
   task master_a(input logic [7:0] d);
      int n, pre;
      pre = na;
      a_sel <= 1'b0;
      txd[7:0] <= d;
      repeat (4) @(posedge clk_in);
      start[0] <= 1'b1;
      @(posedge clk_in);
      start[0] <= 1'b0;
      repeat (30) @(posedge clk_in);
      chk("master clock enable", 8'h01, {7'h00, pout[0].sclk_oe});
      chk("master select", 8'h03, {6'h00, pout[0].sel_n, pout[0].sel_oe});
      chk("master out enable", 8'h01, {7'h00, pout[0].serial_out_oe});
      start[0] <= 1'b1;
      txd[7:0] <= ~d;
      @(posedge clk_in);
      start[0] <= 1'b0;
      n = 0;
      while (busy[0] !== 1'b0 && n < 400) begin
         @(posedge clk_in);
         n++;
      end
      chk("master busy", 8'h00, {7'h00, busy[0]});
      repeat (6) @(posedge clk_in);
      a_sel <= 1'b1;
      chk("master byte count", 8'h01, 8'(na - pre));
      chk("master received", far_tx, got_a);
      chk("slave model received", d, far_rx);
   endtask : master_a
   task slave_b(input logic [7:0] m);
      logic [7:0] s;
      int i, pre;
      pre = nb;
      b_sel_n <= 1'b0;
      repeat (8) @(posedge clk_in);
      for (i = 7; i >= 0; i--) begin
         b_mosi <= m[i];
         repeat (5) @(posedge clk_in);
         @(negedge clk_in) s[i] = pout[1].serial_out;
         @(posedge clk_in) b_sclk <= 1'b1;
         repeat (6) @(posedge clk_in);
         b_sclk <= 1'b0;
      end
      repeat (12) @(posedge clk_in);
      chk("slave sent", txd[15:8], s);
      chk("slave received", m, got_b);
      chk("slave drives", 8'h01, {7'h00, pout[1].serial_out_oe});
      b_sel_n <= 1'b1;
      for (i = 0; i < 16; i++) begin
         b_mosi <= 1'(i);
         repeat (6) @(posedge clk_in);
         b_sclk <= ~b_sclk;
      end
      repeat (8) @(posedge clk_in);
      chk("slave byte count", 8'h01, 8'(nb - pre));
      chk("slave released", 8'h00, {7'h00, pout[1].serial_out_oe});
      chk("slave pin drives", 8'h00, {6'h00, pout[1].sel_oe, pout[1].sclk_oe});
   endtask : slave_b
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      void'($urandom(32'h9bea92bc));
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      master_a(8'h80);
      slave_b(8'h01);
      for (int k = 0; k < 6; k++) begin
         far_tx <= 8'($urandom);
         a_own <= 1'($urandom);
         txd[15:8] <= 8'($urandom);
         // Far byte must settle before the model loads it on select low
         @(posedge clk_in);
         master_a(8'($urandom));
         slave_b(8'($urandom));
      end
      // Port a turned slave while its own select stays high
      a_own <= 1'b1;
      mode <= 2'h0;
      repeat (8) @(posedge clk_in);
      chk("a slave pin drives", 8'h00, {6'h00, pout[0].sel_oe, pout[0].sclk_oe});
      chk("a slave released", 8'h00, {7'h00, pout[0].serial_out_oe});
      conclude;
   end
   initial begin
      #100000;
      err_count++;
      conclude;
   end
endmodule : testbench
